/* ceg_core.sv */
// complementary event timing core with register port
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "ceg_regs.svh"
// Summary of operation
// - rising event: primary held off for rising dead band after complementary off.
// - falling event: complementary held off for falling dead band after primary off.
// - falling event during rising dead band extends it by falling dead band.
// - rising event during falling dead band extends it by rising dead band.
// - falling blank masks rising inputs; rising blank masks falling inputs.
// - blanking counts clock periods from zero up to the setting.
// - falling blank starts when rising event output drive goes false.
// - rising blank starts when falling event output drive goes false.
// - zero blank setting disables blanking; events pass straight through.
// - async sources vary blanking time by at most one clock period.
// - non-zero phase setting delays event assertion by that count.
// - phase delay counts clock periods like dead band and blanking.
// - zero phase setting disables phase delay; event passes directly.
module ceg_core
  import ceg_pkg::*;
#(
  parameter int CNT_W = 6
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic rise_src_in,
  input wire logic fall_src_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic primary_out,
  output logic compl_out
);
  // ---------------------------------------------
  // register port
  // ---------------------------------------------
  ceg_bus_t bus;
  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  logic [CNT_W-1:0] rise_db_reg, fall_db_reg;
  logic [CNT_W-1:0] rising_blank_count, falling_blank_count;
  logic [CNT_W-1:0] rising_phase_count, falling_phase_count;
  logic enable_reg;
  ceg_state_t p_st_reg, c_st_reg;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_db_reg <= '0;
      fall_db_reg <= '0;
      rising_blank_count <= '0;
      falling_blank_count <= '0;
      rising_phase_count <= '0;
      falling_phase_count <= '0;
      enable_reg <= 1'b0;
    end else if (bus.wr) begin
      case (bus.addr)
        `CEG_ADDR_RISE_DB: rise_db_reg <= bus.wdata[CNT_W-1:0];
        `CEG_ADDR_FALL_DB: fall_db_reg <= bus.wdata[CNT_W-1:0];
        `CEG_ADDR_RISE_BLANK: rising_blank_count <= bus.wdata[CNT_W-1:0];
        `CEG_ADDR_FALL_BLANK: falling_blank_count <= bus.wdata[CNT_W-1:0];
        `CEG_ADDR_RISE_PHASE: rising_phase_count <= bus.wdata[CNT_W-1:0];
        `CEG_ADDR_FALL_PHASE: falling_phase_count <= bus.wdata[CNT_W-1:0];
        `CEG_ADDR_CTRL: enable_reg <= bus.wdata[`CEG_CTRL_EN_BIT];
        default: ;
      endcase
    end
  end

  logic [7:0] rdata_next;
  logic rise_blanking, fall_blanking;
  always_comb begin
    rdata_next = 8'h00;
    case (bus.addr)
      `CEG_ADDR_RISE_DB: rdata_next[CNT_W-1:0] = rise_db_reg;
      `CEG_ADDR_FALL_DB: rdata_next[CNT_W-1:0] = fall_db_reg;
      `CEG_ADDR_RISE_BLANK: rdata_next[CNT_W-1:0] = rising_blank_count;
      `CEG_ADDR_FALL_BLANK: rdata_next[CNT_W-1:0] = falling_blank_count;
      `CEG_ADDR_RISE_PHASE: rdata_next[CNT_W-1:0] = rising_phase_count;
      `CEG_ADDR_FALL_PHASE: rdata_next[CNT_W-1:0] = falling_phase_count;
      `CEG_ADDR_CTRL: rdata_next[0] = enable_reg;
      `CEG_ADDR_STATUS: rdata_next = {2'h0, rise_blanking, fall_blanking,
                                      c_st_reg, p_st_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) rdata_out <= 8'h00;
    else if (bus.rd) rdata_out <= rdata_next;
    else rdata_out <= 8'h00;
  end

  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  logic [2:0] rise_sync_reg, fall_sync_reg;
  logic rise_lvl_reg, fall_lvl_reg;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_sync_reg <= 3'h0;
      fall_sync_reg <= 3'h0;
      rise_lvl_reg <= 1'b0;
      fall_lvl_reg <= 1'b0;
    end else begin
      rise_sync_reg <= {rise_sync_reg[1:0], rise_src_in};
      fall_sync_reg <= {fall_sync_reg[1:0], fall_src_in};
      // a change counts only once stages two and three agree
      if (rise_sync_reg[1] == rise_sync_reg[2]) rise_lvl_reg <= rise_sync_reg[2];
      if (fall_sync_reg[1] == fall_sync_reg[2]) fall_lvl_reg <= fall_sync_reg[2];
    end
  end
  logic rise_edge, fall_edge;
  logic rise_lvl_d_reg, fall_lvl_d_reg;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_lvl_d_reg <= 1'b0;
      fall_lvl_d_reg <= 1'b0;
    end else begin
      rise_lvl_d_reg <= rise_lvl_reg;
      fall_lvl_d_reg <= fall_lvl_reg;
    end
  end
  // sync latency gives up to one clock of blanking uncertainty
  assign rise_edge = rise_lvl_reg & ~rise_lvl_d_reg;
  assign fall_edge = fall_lvl_reg & ~fall_lvl_d_reg;

  // ---------------------------------------------
  // blanking
  // ---------------------------------------------
  logic [CNT_W-1:0] rblk_cnt_reg, fblk_cnt_reg;
  logic rise_drive, fall_drive;
  logic rise_drive_d_reg, fall_drive_d_reg;
  logic rise_blank_start, fall_blank_start;
  assign rise_blank_start = fall_drive_d_reg & ~fall_drive;
  assign fall_blank_start = rise_drive_d_reg & ~rise_drive;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rblk_cnt_reg <= '0;
      rise_blanking <= 1'b0;
    end else if (rising_blank_count == '0) begin
      rise_blanking <= 1'b0;
      rblk_cnt_reg <= '0;
    end else if (rise_blank_start) begin
      rise_blanking <= 1'b1;
      rblk_cnt_reg <= '0;
    end else if (rise_blanking) begin
      rblk_cnt_reg <= rblk_cnt_reg + 1'b1;
      if (rblk_cnt_reg == rising_blank_count - 1'b1) rise_blanking <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fblk_cnt_reg <= '0;
      fall_blanking <= 1'b0;
    end else if (falling_blank_count == '0) begin
      fall_blanking <= 1'b0;
      fblk_cnt_reg <= '0;
    end else if (fall_blank_start) begin
      fall_blanking <= 1'b1;
      fblk_cnt_reg <= '0;
    end else if (fall_blanking) begin
      fblk_cnt_reg <= fblk_cnt_reg + 1'b1;
      if (fblk_cnt_reg == falling_blank_count - 1'b1) fall_blanking <= 1'b0;
    end
  end
  logic rise_trig, fall_trig;
  assign rise_trig = rise_edge & ~fall_blanking & enable_reg;
  assign fall_trig = fall_edge & ~rise_blanking & enable_reg;

  // ---------------------------------------------
  // phase delay
  // ---------------------------------------------
  logic [CNT_W-1:0] rph_cnt_reg, fph_cnt_reg;
  logic rph_busy_reg, fph_busy_reg;
  logic rise_evt, fall_evt;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rph_cnt_reg <= '0;
      rph_busy_reg <= 1'b0;
    end else if (rise_trig && rising_phase_count != '0) begin
      rph_busy_reg <= 1'b1;
      rph_cnt_reg <= '0;
    end else if (rph_busy_reg) begin
      rph_cnt_reg <= rph_cnt_reg + 1'b1;
      if (rph_cnt_reg == rising_phase_count - 1'b1) rph_busy_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fph_cnt_reg <= '0;
      fph_busy_reg <= 1'b0;
    end else if (fall_trig && falling_phase_count != '0) begin
      fph_busy_reg <= 1'b1;
      fph_cnt_reg <= '0;
    end else if (fph_busy_reg) begin
      fph_cnt_reg <= fph_cnt_reg + 1'b1;
      if (fph_cnt_reg == falling_phase_count - 1'b1) fph_busy_reg <= 1'b0;
    end
  end
  assign rise_evt = (rise_trig && rising_phase_count == '0) ||
                    (rph_busy_reg && rph_cnt_reg == rising_phase_count - 1'b1);
  assign fall_evt = (fall_trig && falling_phase_count == '0) ||
                    (fph_busy_reg && fph_cnt_reg == falling_phase_count - 1'b1);

  // ---------------------------------------------
  // event drive and dead band
  // ---------------------------------------------
  // rise_drive true from rising event until falling event, and vice versa
  logic rdrv_reg;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) rdrv_reg <= 1'b0;
    else if (!enable_reg) rdrv_reg <= 1'b0;
    else if (fall_evt) rdrv_reg <= 1'b0;
    else if (rise_evt) rdrv_reg <= 1'b1;
  end
  assign rise_drive = rdrv_reg;
  assign fall_drive = enable_reg & ~rdrv_reg & (fall_drive_d_reg | fall_evt | rise_drive_d_reg);
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_drive_d_reg <= 1'b0;
      fall_drive_d_reg <= 1'b0;
    end else begin
      rise_drive_d_reg <= rise_drive;
      fall_drive_d_reg <= fall_drive;
    end
  end

  // one dead-band counter per side; a new event restarts the other side
  logic [CNT_W-1:0] p_cnt_reg, c_cnt_reg;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      p_st_reg <= CEG_IDLE;
      p_cnt_reg <= '0;
    end else begin
      case (p_st_reg)
        CEG_IDLE: if (rise_evt && !fall_evt) begin
          p_st_reg <= (rise_db_reg == '0) ? CEG_ON : CEG_DEAD;
          p_cnt_reg <= '0;
        end
        CEG_DEAD: if (fall_evt || !enable_reg) begin
          p_st_reg <= CEG_IDLE;
        end else if (p_cnt_reg == rise_db_reg - 1'b1) begin
          p_st_reg <= CEG_ON;
        end else begin
          p_cnt_reg <= p_cnt_reg + 1'b1;
        end
        CEG_ON: if (fall_evt || !enable_reg) p_st_reg <= CEG_IDLE;
        default: p_st_reg <= CEG_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      c_st_reg <= CEG_IDLE;
      c_cnt_reg <= '0;
    end else begin
      case (c_st_reg)
        CEG_IDLE: if (fall_evt && !rise_evt && enable_reg) begin
          c_st_reg <= (fall_db_reg == '0) ? CEG_ON : CEG_DEAD;
          c_cnt_reg <= '0;
        end
        CEG_DEAD: if (rise_evt || !enable_reg) begin
          c_st_reg <= CEG_IDLE;
        end else if (c_cnt_reg == fall_db_reg - 1'b1) begin
          c_st_reg <= CEG_ON;
        end else begin
          c_cnt_reg <= c_cnt_reg + 1'b1;
        end
        CEG_ON: if (rise_evt || !enable_reg) c_st_reg <= CEG_IDLE;
        default: c_st_reg <= CEG_IDLE;
      endcase
    end
  end
  // overlap: the falling count restarts from the falling event, so the
  // total dead time is the part of rising dead band spent plus falling dead band

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      primary_out <= 1'b0;
      compl_out <= 1'b0;
    end else begin
      primary_out <= (p_st_reg == CEG_ON) && !fall_evt && enable_reg;
      compl_out <= (c_st_reg == CEG_ON) && !rise_evt && enable_reg;
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  property p_no_overlap;
    @(posedge clk_sys_in) disable iff (!rst_n_in) !(primary_out && compl_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both outputs on");
  property p_rise_db;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(primary_out) |-> $past(p_st_reg) == CEG_ON;
  endproperty
  a_rise_db: assert property (p_rise_db) else $error("primary on without dead band");
  property p_fall_db;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(compl_out) |-> $past(c_st_reg) == CEG_ON;
  endproperty
  a_fall_db: assert property (p_fall_db) else $error("compl on without dead band");
  property p_ext_fall;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (p_st_reg == CEG_DEAD && fall_evt) |=> p_st_reg == CEG_IDLE ##0 !primary_out;
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("primary not suppressed");
  property p_ext_rise;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (c_st_reg == CEG_DEAD && rise_evt) |=> c_st_reg == CEG_IDLE ##0 !compl_out;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("compl not suppressed");
  property p_blank_mask;
    @(posedge clk_sys_in) disable iff (!rst_n_in) (fall_blanking && !rph_busy_reg) |-> !rise_evt;
  endproperty
  a_blank_mask: assert property (p_blank_mask) else $error("rising input not blanked");
  property p_blank_start;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (fall_blank_start && falling_blank_count != '0) |=> fall_blanking;
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("falling blank not started");
  property p_blank_off;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (rising_blank_count == '0) |=> !rise_blanking;
  endproperty
  a_blank_off: assert property (p_blank_off) else $error("zero blank still blanking");
  property p_phase_zero;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      (rise_trig && rising_phase_count == '0) |-> rise_evt;
  endproperty
  a_phase_zero: assert property (p_phase_zero) else $error("phase delay not bypassed");
  c_primary: cover property (@(posedge clk_sys_in) $rose(primary_out));
  c_compl: cover property (@(posedge clk_sys_in) $rose(compl_out));
  c_overlap: cover property (@(posedge clk_sys_in) p_st_reg == CEG_DEAD && fall_evt);
  c_blank: cover property (@(posedge clk_sys_in) fall_blanking && rise_edge);
endmodule : ceg_core

/* ceg_pkg.sv */
// types of the complementary event timing block
package ceg_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ceg_bus_t;
  typedef enum logic [1:0] {
    CEG_IDLE = 2'b00,
    CEG_DEAD = 2'b01,
    CEG_ON = 2'b10
  } ceg_state_t;
endpackage : ceg_pkg

/* ceg_regs.svh */
// constants of the complementary event timing block
`ifndef CEG_REGS_SVH
`define CEG_REGS_SVH
`define CEG_ADDR_W 3
`define CEG_ADDR_RISE_DB 3'h0
`define CEG_ADDR_FALL_DB 3'h1
`define CEG_ADDR_RISE_BLANK 3'h2
`define CEG_ADDR_FALL_BLANK 3'h3
`define CEG_ADDR_RISE_PHASE 3'h4
`define CEG_ADDR_FALL_PHASE 3'h5
`define CEG_ADDR_CTRL 3'h6
`define CEG_ADDR_STATUS 3'h7
`define CEG_CTRL_EN_BIT 0
`define CEG_CNT_RESET 6'h00
`define CEG_CLK_PERIOD_NS 4
`endif

/* ceg_src_model.sv */
// event source model standing in for the on-chip trigger sources
`timescale 1ns/1ps
module ceg_src_model (
  output logic rise_src_out,
  output logic fall_src_out
);
  // ----------------------------------------
  // source pulses
  // ----------------------------------------
  initial begin
    rise_src_out = 1'b0;
    fall_src_out = 1'b0;
  end
  // skew keeps the edges unrelated to the bench clock
  task automatic pulse(input int k, input int skew_ps);
    #(skew_ps * 0.001);
    if (k == 0) rise_src_out = 1'b1;
    else fall_src_out = 1'b1;
    // two and a half periods: two clean samples whatever the phase of the edge
    #10;
    rise_src_out = 1'b0;
    fall_src_out = 1'b0;
  endtask : pulse
endmodule : ceg_src_model

/* tb_top.sv */
// self-checking bench for the complementary event timing core
`timescale 1ns/1ps
`include "ceg_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic primary_out;
  logic compl_out;
  wire logic rise_src_in;
  wire logic fall_src_in;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 32'h0c4b;
  int n, b0, b1, d, bl;
  logic [7:0] v;
  logic [7:0] exp_v [6];
  ceg_core #(.CNT_W(6)) ceg_core_i (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .rise_src_in(rise_src_in),
    .fall_src_in(fall_src_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .primary_out(primary_out), .compl_out(compl_out));
  ceg_src_model ceg_src_model_i (.rise_src_out(rise_src_in), .fall_src_out(fall_src_in));
  initial forever #2 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------
  // register port and event helpers
  // ----------------------------------------
  task automatic wreg(input logic [2:0] a, input logic [7:0] dv);
    @(posedge clk_sys_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= dv;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [2:0] a, output logic [7:0] dv);
    @(posedge clk_sys_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    dv = rdata_out;
  endtask : rreg
  function automatic logic outv(input int k);
    return (k == 0) ? primary_out : compl_out;
  endfunction : outv
  // bounded wait, counted in whole clock periods
  task automatic wait_lvl(input int k, input logic lv, output int cnt);
    cnt = 0;
    while (outv(k) !== lv && cnt < 400) begin
      @(posedge clk_sys_in);
      #1;
      cnt++;
    end
    `CHK(outv(k), lv)
  endtask : wait_lvl
  task automatic ev(input int k);
    ceg_src_model_i.pulse(k, {$random(seed)} % 4000);
  endtask : ev
  task automatic go(input int k);
    int c;
    ev(k);
    wait_lvl(k, 1'b1, c);
    `CHK(outv(k), 1'b1)
  endtask : go
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rreg(3'(a), v);
      `CHK(v, 8'h00)
    end
    for (int a = 0; a < 6; a++) begin
      exp_v[a] = 8'($random(seed));
      wreg(3'(a), exp_v[a]);
    end
    for (int a = 0; a < 6; a++) begin
      rreg(3'(a), v);
      `CHK(v, exp_v[a] & 8'h3f)
    end
    wreg(`CEG_ADDR_CTRL, 8'hff);
    rreg(`CEG_ADDR_CTRL, v);
    `CHK(v, 8'h01)
    @(posedge clk_sys_in);
    #1;
    `CHK(rdata_out, 8'h00)
    for (int a = 0; a < 7; a++) wreg(3'(a), 8'h00);
    ev(0);
    repeat (30) @(posedge clk_sys_in);
    `CHK({primary_out, compl_out}, 2'b00)
    wreg(`CEG_ADDR_CTRL, 8'h01);
    $display("test registers done");
    // gap between one drive dropping and the other rising grows with the setting
    for (int i = 0; i < 3; i++) begin
      d = i * (i + 2);
      wreg(3'h0, 8'(d));
      wreg(3'h1, 8'(d));
      go(0);
      ev(1);
      wait_lvl(0, 1'b0, n);
      wait_lvl(1, 1'b1, n);
      if (d == 0) b1 = n;
      `CHK(n, b1 + d)
      ev(0);
      wait_lvl(1, 1'b0, n);
      wait_lvl(0, 1'b1, n);
      if (d == 0) b0 = n;
      `CHK(n, b0 + d)
    end
    $display("test deadband done");
    for (int k = 0; k < 2; k++) begin
      wreg(3'(k), 8'h14);
      wreg(3'(1 - k), 8'h03);
      go(1 - k);
      ev(k);
      ev(1 - k);
      v[0] = 1'b0;
      repeat (80) begin
        @(posedge clk_sys_in);
        #1;
        if (outv(k) === 1'b1) v[0] = 1'b1;
      end
      `CHK(v[0], 1'b0)
      `CHK(outv(1 - k), 1'b1)
      wreg(3'(k), 8'h00);
      wreg(3'(1 - k), 8'h00);
    end
    $display("test overlap done");
    // an event straight after its own drive drops lands inside the blank
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 2; i++) begin
        bl = (i == 0) ? 20 : 0;
        wreg(3'(3 - k), 8'(bl));
        go(k);
        ev(1 - k);
        wait_lvl(k, 1'b0, n);
        ev(k);
        repeat (60) @(posedge clk_sys_in);
        #1;
        `CHK(outv(1 - k), logic'(bl != 0))
        `CHK(outv(k), logic'(bl == 0))
        wreg(3'(3 - k), 8'h00);
      end
    end
    $display("test blanking done");
    for (int k = 0; k < 2; k++) begin
      for (int p = 0; p < 2; p++) begin
        wreg(3'(4 + k), 8'(p * 5));
        go(1 - k);
        // fixed offset from an edge keeps the measured delay free of sync jitter
        @(posedge clk_sys_in);
        fork
          ceg_src_model_i.pulse(k, 1000);
          wait_lvl(1 - k, 1'b0, n);
        join
        if (p == 0) b0 = n;
        `CHK(n, b0 + p * 5)
        wait_lvl(k, 1'b1, n);
        wreg(3'(4 + k), 8'h00);
      end
    end
    $display("test phase done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    mismatches++;
    stop_test();
  end
endmodule : tb_top
